// [core/art_timer.v]
// auto-reload timer with external oscillator capture and register port
// assumes a single 100 MHz clock; extClk is an asynchronous pin
//
// Added by the designer: the register addresses and the plain strobed port.
module art_timer (
    input  wire       clk,
    input  wire       resetn,
    input  wire       ce,
    input  wire       extClk,
    input  wire [3:0] addr,
    input  wire [7:0] wdata,
    input  wire       wrStb,
    input  wire       rdStb,
    output reg  [7:0] rdata,
    output reg        irq
);
`include "art_timer_defs.vh"

    // clock tick select for one byte
    function selTick;
        input fast;
        input xclk;
        input extT;
        input d12T;
        begin
            selTick = fast ? 1'b1 : (xclk ? extT : d12T);
        end
    endfunction

    // next byte value: reload on wrap, else increment
    function [7:0] stepByte;
        input [7:0] cur;
        input [7:0] rel;
        input       wrap;
        begin
            stepByte = wrap ? rel : cur + 8'h01;
        end
    endfunction

    // strobe decode for one register index
    function regHit;
        input       stb;
        input [3:0] a;
        input [3:0] idx;
        begin
            regHit = stb && (a == idx);
        end
    endfunction

    reg  [7:0] countLo;
    reg  [7:0] countHi;
    reg  [7:0] reloadLo;
    reg  [7:0] reloadHi;
    reg        highOverflowFlag;
    reg        lowOverflowFlag;
    reg        lowByteIrqEnable;
    reg        captureModeEnable;
    reg        splitModeEnable;
    reg        runControl;
    reg        externalClockSelect;
    reg        lowByteFastClockSelect;
    reg        highByteFastClockSelect;
    reg  [1:0] irqStat;
    reg  [1:0] irqMask;

    wire       div12Tick;
    wire       extTick;
    wire       extFall;

    art_prescale uPre (
        .clk       (clk),
        .resetn    (resetn),
        .ce        (ce),
        .extClk    (extClk),
        .div12Tick (div12Tick),
        .extTick   (extTick),
        .extFall   (extFall)
    );

    reg        tickLo;
    reg        tickHi;
    reg        capTick;
    reg        mode16;
    reg        adv16;
    reg        advLo;
    reg        advHi;
    reg        lowWrap;
    reg        highWrap;
    reg        capEvt;
    reg  [7:0] next_countLo;
    reg  [7:0] next_countHi;
    reg  [7:0] next_reloadLo;
    reg  [7:0] next_reloadHi;
    reg        setHigh;
    reg        setLow;
    reg  [1:0] next_irqStat;

    reg        next_irq;
    reg  [7:0] next_rdata;

    wire       wrCtrl;
    wire       rdStat;
    wire       wrCountLo;
    wire       wrCountHi;
    wire       wrReloadLo;
    wire       wrReloadHi;
    wire       wrClkCtl;
    wire       wrMask;

    assign wrCtrl     = regHit(wrStb, addr, `ART_ADDR_CTRL);
    assign rdStat     = regHit(rdStb, addr, `ART_ADDR_IRQ_STAT);
    assign wrCountLo  = regHit(wrStb, addr, `ART_ADDR_COUNT_LO);
    assign wrCountHi  = regHit(wrStb, addr, `ART_ADDR_COUNT_HI);
    assign wrReloadLo = regHit(wrStb, addr, `ART_ADDR_RELOAD_LO);
    assign wrReloadHi = regHit(wrStb, addr, `ART_ADDR_RELOAD_HI);
    assign wrClkCtl   = regHit(wrStb, addr, `ART_ADDR_CLKCTL);
    assign wrMask     = regHit(wrStb, addr, `ART_ADDR_IRQ_MASK);

    always @* begin
        tickLo  = selTick(lowByteFastClockSelect, externalClockSelect,
                          extTick, div12Tick);
        tickHi  = selTick(highByteFastClockSelect, externalClockSelect,
                          extTick, div12Tick);
        // capture counts only on internal clocks
        capTick = lowByteFastClockSelect | div12Tick;
        // capture forces whole-counter operation
        mode16  = !splitModeEnable || captureModeEnable;
        adv16   = runControl &&
                  (captureModeEnable ? capTick : tickLo);
        advLo   = mode16 ? adv16 : tickLo;
        advHi   = mode16 ? adv16 && (countLo == `ART_BYTE_MAX)
                         : runControl && tickHi;
        lowWrap  = advLo && (countLo == `ART_BYTE_MAX);
        highWrap = advHi && (countHi == `ART_BYTE_MAX);
        capEvt   = captureModeEnable && extFall;

        next_countLo  = countLo;
        next_countHi  = countHi;
        next_reloadLo = reloadLo;
        next_reloadHi = reloadHi;
        if (mode16) begin
            if (adv16) begin
                if (highWrap && !captureModeEnable) begin
                    next_countLo = reloadLo;
                    next_countHi = reloadHi;
                end else begin
                    next_countLo = countLo + 8'h01;
                    if (advHi)
                        next_countHi = countHi + 8'h01;
                end
            end
        end else begin
            if (advLo)
                next_countLo = stepByte(countLo, reloadLo, lowWrap);
            if (advHi)
                next_countHi = stepByte(countHi, reloadHi, highWrap);
        end
        // software writes override the count
        if (wrCountLo)
            next_countLo = wdata;
        if (wrCountHi)
            next_countHi = wdata;
        if (wrReloadLo)
            next_reloadLo = wdata;
        if (wrReloadHi)
            next_reloadHi = wdata;
        // capture wins over a software reload write in the same cycle
        if (capEvt) begin
            next_reloadLo = countLo;
            next_reloadHi = countHi;
        end

        setHigh = (highWrap && !captureModeEnable) || capEvt;
        setLow  = lowWrap;

        // sticky irq status, cleared by read, a new set wins
        next_irqStat = rdStat ? `ART_RST_IRQ : irqStat;
        if (setHigh)
            next_irqStat[`ART_IRQ_HIGH] = 1'b1;
        if (setLow && lowByteIrqEnable)
            next_irqStat[`ART_IRQ_LOW] = 1'b1;

        // low source needs the high mask too: timer irqs must be on
        next_irq = (irqStat[`ART_IRQ_HIGH] & irqMask[`ART_IRQ_HIGH]) |
                   (irqStat[`ART_IRQ_LOW] & irqMask[`ART_IRQ_LOW] &
                    irqMask[`ART_IRQ_HIGH]);

        // read data stand for one cycle only
        next_rdata = `ART_RST_BYTE;
        if (rdStb) begin
            case (addr)
                `ART_ADDR_CTRL:
                    next_rdata = {highOverflowFlag, lowOverflowFlag,
                                  lowByteIrqEnable, captureModeEnable,
                                  splitModeEnable, runControl, 1'b0,
                                  externalClockSelect};
                `ART_ADDR_CLKCTL:
                    next_rdata = {6'h00, highByteFastClockSelect,
                                  lowByteFastClockSelect};
                `ART_ADDR_RELOAD_LO: next_rdata = reloadLo;
                `ART_ADDR_RELOAD_HI: next_rdata = reloadHi;
                `ART_ADDR_COUNT_LO:  next_rdata = countLo;
                `ART_ADDR_COUNT_HI:  next_rdata = countHi;
                `ART_ADDR_IRQ_STAT:  next_rdata = {6'h00, irqStat};
                `ART_ADDR_IRQ_MASK:  next_rdata = {6'h00, irqMask};
                default:             next_rdata = `ART_RST_BYTE;
            endcase
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            countLo                 <= `ART_RST_BYTE;
            countHi                 <= `ART_RST_BYTE;
            reloadLo                <= `ART_RST_BYTE;
            reloadHi                <= `ART_RST_BYTE;
            highOverflowFlag        <= 1'b0;
            lowOverflowFlag         <= 1'b0;
            lowByteIrqEnable        <= 1'b0;
            captureModeEnable       <= 1'b0;
            splitModeEnable         <= 1'b0;
            runControl              <= 1'b0;
            externalClockSelect     <= 1'b0;
            lowByteFastClockSelect  <= 1'b0;
            highByteFastClockSelect <= 1'b0;
            irqStat                 <= `ART_RST_IRQ;
            irqMask                 <= `ART_RST_IRQ;
            rdata                   <= `ART_RST_BYTE;
            irq                     <= 1'b0;
        end else if (ce) begin
            countLo  <= next_countLo;
            countHi  <= next_countHi;
            reloadLo <= next_reloadLo;
            reloadHi <= next_reloadHi;
            irqStat  <= next_irqStat;

            // flags cleared only by software; a same-cycle set wins
            if (wrCtrl) begin
                highOverflowFlag <= wdata[`ART_CTRL_HOF] | setHigh;
                lowOverflowFlag  <= wdata[`ART_CTRL_LOF] | setLow;
                lowByteIrqEnable    <= wdata[`ART_CTRL_LIRQEN];
                captureModeEnable   <= wdata[`ART_CTRL_CAPEN];
                splitModeEnable     <= wdata[`ART_CTRL_SPLIT];
                runControl          <= wdata[`ART_CTRL_RUN];
                externalClockSelect <= wdata[`ART_CTRL_XCLK];
            end else begin
                highOverflowFlag <= highOverflowFlag | setHigh;
                lowOverflowFlag  <= lowOverflowFlag | setLow;
            end

            if (wrClkCtl) begin
                lowByteFastClockSelect  <= wdata[`ART_CLK_LOFAST];
                highByteFastClockSelect <= wdata[`ART_CLK_HIFAST];
            end
            if (wrMask)
                irqMask <= wdata[1:0];

            irq   <= next_irq;
            rdata <= next_rdata;
        end
    end
endmodule // art_timer

// [core/art_timer_defs.vh]
// constants for the auto-reload timer with capture
// assumes a 100 MHz system clock and a 4-bit word-indexed register port
`ifndef ART_TIMER_DEFS_VH
`define ART_TIMER_DEFS_VH

// register addresses
`define ART_ADDR_CTRL      4'h0
`define ART_ADDR_CLKCTL    4'h1
`define ART_ADDR_RELOAD_LO 4'h2
`define ART_ADDR_RELOAD_HI 4'h3
`define ART_ADDR_COUNT_LO  4'h4
`define ART_ADDR_COUNT_HI  4'h5
`define ART_ADDR_IRQ_STAT  4'h6
`define ART_ADDR_IRQ_MASK  4'h7

// timer control register fields
`define ART_CTRL_HOF     7
`define ART_CTRL_LOF     6
`define ART_CTRL_LIRQEN  5
`define ART_CTRL_CAPEN   4
`define ART_CTRL_SPLIT   3
`define ART_CTRL_RUN     2
`define ART_CTRL_XCLK    0

// clock control register fields
`define ART_CLK_LOFAST   0
`define ART_CLK_HIFAST   1

// interrupt status and mask fields
`define ART_IRQ_HIGH     0
`define ART_IRQ_LOW      1

// reset values
`define ART_RST_BYTE     8'h00
`define ART_RST_IRQ      2'h0

// timing counts
`define ART_DIV12_LAST   4'hB
`define ART_DIV8_BITS    3
`define ART_BYTE_MAX     8'hFF

`endif

// [core/art_prescale.v]
// clock prescaler: system clock /12 tick, external oscillator /8
// assumes extClk is asynchronous to clk; ce freezes all state
module art_prescale (
    input  wire       clk,
    input  wire       resetn,
    input  wire       ce,
    input  wire       extClk,
    output reg        div12Tick,
    output reg        extTick,
    output reg        extFall
);
`include "art_timer_defs.vh"

    reg  [2:0] syncExt;
    reg        extLevel;
    reg  [3:0] div12Cnt;
    reg  [`ART_DIV8_BITS-1:0] div8Cnt;
    wire       extRise;
    wire [`ART_DIV8_BITS-1:0] next_div8Cnt;

    // a change counts only once stages two and three agree
    assign extRise = (syncExt[1] == syncExt[2]) && syncExt[2] && !extLevel;
    assign next_div8Cnt = div8Cnt + 1'b1;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            syncExt   <= 3'h0;
            extLevel  <= 1'b0;
            div12Cnt  <= 4'h0;
            div8Cnt   <= 3'h0;
            div12Tick <= 1'b0;
            extTick   <= 1'b0;
            extFall   <= 1'b0;
        end else if (ce) begin
            syncExt <= {syncExt[1:0], extClk};
            if (syncExt[1] == syncExt[2])
                extLevel <= syncExt[2];
            div12Tick <= (div12Cnt == `ART_DIV12_LAST);
            if (div12Cnt == `ART_DIV12_LAST)
                div12Cnt <= 4'h0;
            else
                div12Cnt <= div12Cnt + 4'h1;
            // divided clock is the top bit; rising edge ticks, falling captures
            extTick <= 1'b0;
            extFall <= 1'b0;
            if (extRise) begin
                div8Cnt <= next_div8Cnt;
                extTick <= !div8Cnt[2] && next_div8Cnt[2];
                extFall <= div8Cnt[2] && !next_div8Cnt[2];
            end
        end
    end
endmodule // art_prescale

// [test/art_timer_checker.sv]
// port-level checks on the timer register port and irq line
// assumes one clock and an active-low asynchronous reset
module art_timer_checker (
    input wire       clk,
    input wire       resetn,
    input wire       ce,
    input wire       extClk,
    input wire [3:0] addr,
    input wire [7:0] wdata,
    input wire       wrStb,
    input wire       rdStb,
    input wire [7:0] rdata,
    input wire       irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!resetn);
    wire rd = rdStb && ce;
    wire wr = wrStb && ce;
    property p_rdIdle;
        !rd |=> rdata == 8'h00;
    endproperty
    a_rdIdle: assert property (p_rdIdle) else $error("stray read data");
    property p_unmapped;
        rd && addr[3] |=> rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_spareBit;
        rd && addr == 4'h0 |=> !rdata[1];
    endproperty
    a_spareBit: assert property (p_spareBit) else $error("spare bit set");
    property p_ctrlBack;
        wr && addr == 4'h0 ##1 rd && addr == 4'h0
            |=> (rdata & 8'h3D) == ($past(wdata, 2) & 8'h3D);
    endproperty
    a_ctrlBack: assert property (p_ctrlBack) else $error("ctrl");
    property p_reloadBack;
        wr && addr == 4'h2 ##1 rd && addr == 4'h2
            |=> rdata == $past(wdata, 2);
    endproperty
    a_reloadBack: assert property (p_reloadBack) else $error("rl");
    property p_clkBack;
        wr && addr == 4'h1 ##1 rd && addr == 4'h1
            |=> (rdata & 8'h03) == ($past(wdata, 2) & 8'h03);
    endproperty
    a_clkBack: assert property (p_clkBack) else $error("clk");
    property p_maskBack;
        wr && addr == 4'h7 ##1 rd && addr == 4'h7
            |=> (rdata & 8'h03) == ($past(wdata, 2) & 8'h03);
    endproperty
    a_maskBack: assert property (p_maskBack) else $error("mask");
    property p_irqOff;
        wr && addr == 4'h7 && !wdata[0] ##1 !(wr && addr == 4'h7) |=> !irq;
    endproperty
    a_irqOff: assert property (p_irqOff) else $error("irq masked");
endmodule // art_timer_checker

// [test/art_timer_test.sv]
// self-checking bench for the auto-reload timer with capture
// assumes word-indexed registers and one-cycle read latency
module art_timer_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        ce = 1'b1;
    logic        extClk = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [7:0]  wdata = 8'h00;
    logic        wrStb = 1'b0;
    logic        rdStb = 1'b0;
    wire  [7:0]  rdata;
    wire         irq;
    logic [7:0]  got;
    int          errCount = 0;
    int          nChecks = 0;
    // address, write data, expected read back
    logic [19:0] rows [10] = '{20'h25A5A, 20'h3A5A5, 20'h10303,
        20'h70303, 20'h70000, 20'h02929, 20'h01210, 20'h00000,
        20'h9FF00, 20'h10000};
    art_timer u_art_timer (.clk(clk), .resetn(resetn), .ce(ce),
        .extClk(extClk), .addr(addr), .wdata(wdata), .wrStb(wrStb),
        .rdStb(rdStb), .rdata(rdata), .irq(irq));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [7:0] seen, exp);
        nChecks++;
        if (seen !== exp) begin
            errCount++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input logic w, r, input logic [11:0] ad);
        @(posedge clk);
        wrStb <= w;
        rdStb <= r;
        addr <= ad[11:8];
        wdata <= ad[7:0];
    endtask
    // each write gets an idle cycle so strobes never double-assign
    task automatic wrs(input logic [11:0] l[$]);
        foreach (l[i]) begin
            cyc(1'b1, 1'b0, l[i]);
            cyc(1'b0, 1'b0, l[i]);
        end
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] m, e);
        cyc(1'b0, 1'b1, {a, 8'h00});
        cyc(1'b0, 1'b0, {a, 8'h00});
        #1 got = rdata & m;
        check(got, e);
    endtask
    task automatic idle(input int n);
        repeat (n) cyc(1'b0, 1'b0, 12'h000);
    endtask
    // slow external oscillator, 8 clocks per period
    task automatic ext(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk);
            extClk <= ~extClk;
        end
    endtask
    task automatic rstChk;
        for (int a = 0; a < 8; a++) begin
            rdc(4'(a), 8'hFF, 8'h00);
        end
    endtask
    task automatic tallyAndFinish;
        $display("checks %0d errors %0d", nChecks, errCount);
        if (errCount == 0 && nChecks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        #100us;
        errCount++;
        tallyAndFinish();
    end
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        rstChk();
        foreach (rows[i]) begin
            cyc(1'b1, 1'b0, rows[i][19:8]);
            rdc(rows[i][19:16], 8'hFF, rows[i][7:0]);
        end
        wrs({12'h101, 12'h701, 12'h200, 12'h312, 12'h4FE, 12'h5FF,
            12'h004});
        idle(8);
        rdc(4'h5, 8'hFF, 8'h12);
        rdc(4'h0, 8'hFF, 8'hC4);
        check({7'h00, irq}, 8'h01);
        rdc(4'h6, 8'hFF, 8'h01);
        idle(2);
        #1 check({7'h00, irq}, 8'h00);
        rdc(4'h0, 8'h80, 8'h80);
        wrs({12'h020, 12'h703, 12'h4FE, 12'h500, 12'h024});
        idle(6);
        #1 check({7'h00, irq}, 8'h01);
        rdc(4'h6, 8'hFF, 8'h02);
        rdc(4'h5, 8'hFF, 8'h01);
        wrs({12'h020, 12'h433});
        idle(20);
        rdc(4'h4, 8'hFF, 8'h33);
        wrs({12'h000, 12'h103, 12'h701, 12'h240, 12'h380, 12'h4FE,
            12'h5FE, 12'h008});
        idle(6);
        rdc(4'h5, 8'hFF, 8'hFE);
        rdc(4'h0, 8'hFF, 8'h48);
        rdc(4'h6, 8'hFF, 8'h00);
        rdc(4'h4, 8'hC0, 8'h40);
        wrs({12'h00C});
        idle(6);
        #1 check({7'h00, irq}, 8'h01);
        rdc(4'h5, 8'hC0, 8'h80);
        rdc(4'h0, 8'h80, 8'h80);
        // about 354 cycles on the /12 tick gives 28 to 31 counts
        wrs({12'h000, 12'h100, 12'h700, 12'h400, 12'h500, 12'h004});
        idle(352);
        wrs({12'h000});
        rdc(4'h4, 8'hFC, 8'h1C);
        // 26 rising edges give 3 ticks from the divider's reset phase
        wrs({12'h400, 12'h005});
        ext(52);
        idle(8);
        wrs({12'h000});
        rdc(4'h4, 8'hFF, 8'h03);
        rdc(4'h6, 8'hFF, 8'h01);
        // capture set up in 16-bit mode on the fast clock
        wrs({12'h2AA, 12'h3AA, 12'h101, 12'h400, 12'h500, 12'h014});
        ext(32);
        idle(8);
        rdc(4'h3, 8'hFF, 8'h00);
        rdc(4'h0, 8'h80, 8'h80);
        rdc(4'h6, 8'hFF, 8'h01);
        wrs({12'h000, 12'h25A});
        cyc(1'b0, 1'b1, 12'h200);
        ce <= 1'b0;
        cyc(1'b0, 1'b0, 12'h200);
        ce <= 1'b1;
        #1 check(rdata, 8'h00);
        @(posedge clk);
        resetn <= 1'b0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        rstChk();
        tallyAndFinish();
    end
endmodule // art_timer_test
bind art_timer art_timer_checker u_art_timer_checker (.clk(clk),
    .resetn(resetn), .ce(ce), .extClk(extClk), .addr(addr),
    .wdata(wdata), .wrStb(wrStb), .rdStb(rdStb), .rdata(rdata),
    .irq(irq));
